// File: rtl/atcg_top.sv
// transmit clock generator: master and bit clock dividers, pin steering,
// launch edge selection and sharing of transmit timing with the receiver
// assumes all pin inputs are synchronous to mclk_i and well below its rate
//
// What this block does
// - polarity select 0 launches each data bit on the bit clock rising edge.
// - polarity select 1 launches each data bit on the bit clock falling edge.
// - with independent timing off the receiver uses transmit bit clock and frame sync.
// - with independent timing on each section uses its own bit clock and frame sync.
// - bit clock source select takes the pin at 0 and the bit divider at 1.
// - the 5-bit bit divide field divides the master clock by value plus one.
// - master source select takes the pin at 0 and the master divider at 1.
// - master polarity select inverts the master clock before the bit divider at 1.
// - internal bit clock with divide field 0 passes the master clock to the pin.
// - the 12-bit master divide field divides the auxiliary clock by value plus one.
// - reserved bits read zero and writes to them do nothing.
// - after reset independent timing and both source selects read 1, all else 0.
`timescale 1ns/100ps
`default_nettype none
module atcg_top
	import atcg_pkg::*;
(
	input  wire logic               mclk_i,
	input  wire logic               nrst_i,
	input  wire logic [ATCG_AW-1:0] addr_i,
	input  wire logic [ATCG_DW-1:0] wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [ATCG_DW-1:0] rdata_o,
	input  wire logic               auxiliary_source_clock_i,
	input  wire logic               tx_master_clock_pin_i,
	output logic                    tx_master_clock_pin_o,
	output logic                    tx_master_clock_pin_oe_o,
	input  wire logic               tx_bit_clock_pin_i,
	output logic                    tx_bit_clock_pin_o,
	output logic                    tx_bit_clock_pin_oe_o,
	input  wire logic               tx_frame_sync_i,
	input  wire logic               rx_bit_clock_pin_i,
	input  wire logic               rx_frame_sync_pin_i,
	output logic                    tx_bit_clock_o,
	output logic                    tx_launch_o,
	output logic                    rx_bit_clock_o,
	output logic                    rx_frame_sync_o
);
	typedef struct packed {
		logic [ATCG_DW-1:0] bitctl;
		logic [ATCG_DW-1:0] mstctl;
		logic [ATCG_DW-1:0] rdata;
	} atcg_st_t;

	atcg_st_t st_reg;
	atcg_st_t st_next;

	logic                   bit_pol;
	logic                   indep_rx;
	logic                   bit_src;
	logic [ATCG_BDIV_W-1:0] bit_div;
	logic                   mst_src;
	logic                   mst_pol;
	logic [ATCG_MDIV_W-1:0] mst_div;
	logic                   mst_lvl;
	logic                   bdiv_src;
	logic                   bclk_lvl;
	logic                   bclk_rise;
	logic                   bclk_fall;
	logic [ATCG_ST_W-1:0]   status;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	assign bit_pol  = st_reg.bitctl[ATCG_BPOL_POS];
	assign indep_rx = st_reg.bitctl[ATCG_INDEPENDENT_RX_TIMING_ENABLE_POS];
	assign bit_src  = st_reg.bitctl[ATCG_BSRC_POS];
	assign bit_div  = st_reg.bitctl[ATCG_BDIV_W-1:0];
	assign mst_src  = st_reg.mstctl[ATCG_MSRC_POS];
	assign mst_pol  = st_reg.mstctl[ATCG_MPOL_POS];
	assign mst_div  = st_reg.mstctl[ATCG_MDIV_W-1:0];

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_comb begin
		st_next       = st_reg;
		st_next.rdata = '0;
		// reserved bits masked off on write
		if (wr_i && addr_i == ATCG_BITCTL_OFS) begin
			st_next.bitctl = wdata_i & ATCG_BITCTL_MSK;
		end
		if (wr_i && addr_i == ATCG_MSTCTL_OFS) begin
			st_next.mstctl = wdata_i & ATCG_MSTCTL_MSK;
		end
		// unmapped addresses read zero
		if (rd_i) begin
			case (addr_i)
				ATCG_BITCTL_OFS: st_next.rdata = st_reg.bitctl;
				ATCG_MSTCTL_OFS: st_next.rdata = st_reg.mstctl;
				ATCG_STATUS_OFS: st_next.rdata = {{(ATCG_DW-ATCG_ST_W){1'b0}}, status};
				default:         st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			// reset values of both control words
			st_reg.bitctl <= ATCG_BITCTL_RST;
			st_reg.mstctl <= ATCG_MSTCTL_RST;
			st_reg.rdata  <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;

	// ----------------------------------------
	// master clock stage
	// ----------------------------------------
	atcg_div_if #(.W(ATCG_MDIV_W)) mdiv_if ();
	atcg_div_if #(.W(ATCG_BDIV_W)) bdiv_if ();

	assign mdiv_if.src   = auxiliary_source_clock_i;
	assign mdiv_if.ratio = mst_div;

	atcg_div #(.W(ATCG_MDIV_W)) u_mdiv (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.bus    (mdiv_if.div)
	);

	// master clock from pin or divider
	assign mst_lvl = mst_src ? mdiv_if.clk_out : tx_master_clock_pin_i;
	// optional inversion ahead of bit divider
	assign bdiv_src = mst_lvl ^ mst_pol;

	// ----------------------------------------
	// bit clock stage
	// ----------------------------------------
	assign bdiv_if.src   = bdiv_src;
	assign bdiv_if.ratio = bit_div;

	atcg_div #(.W(ATCG_BDIV_W)) u_bdiv (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.bus    (bdiv_if.div)
	);

	// bit clock from pin, divider, or master pass-through
	always_comb begin
		if (!bit_src) begin
			bclk_lvl = tx_bit_clock_pin_i;
		end else if (bit_div == '0) begin
			bclk_lvl = mst_lvl;
		end else begin
			bclk_lvl = bdiv_if.clk_out;
		end
	end

	// ----------------------------------------
	// pins and timing outputs
	// ----------------------------------------
	// drive a pin only when its clock is made here
	assign tx_master_clock_pin_o    = mdiv_if.clk_out;
	assign tx_master_clock_pin_oe_o = mst_src;
	assign tx_bit_clock_pin_o       = bclk_lvl;
	assign tx_bit_clock_pin_oe_o    = bit_src;
	assign tx_bit_clock_o           = bclk_lvl;

	atcg_edge u_bedge (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.level_i (bclk_lvl),
		.rise_o  (bclk_rise),
		.fall_o  (bclk_fall)
	);

	assign tx_launch_o = bit_pol ? bclk_fall : bclk_rise;

	assign rx_bit_clock_o  = indep_rx ? rx_bit_clock_pin_i : bclk_lvl;
	assign rx_frame_sync_o = indep_rx ? rx_frame_sync_pin_i : tx_frame_sync_i;

	// status shows live clock levels and pin direction
	assign status = {mst_src, bit_src, mst_lvl, bclk_lvl};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_rd_bitctl;
		rd_i && addr_i == ATCG_BITCTL_OFS;
	endsequence
	sequence s_rd_mstctl;
		rd_i && addr_i == ATCG_MSTCTL_OFS;
	endsequence

	a_launch_rise_pol0: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!bit_pol && $rose(bclk_lvl) |-> tx_launch_o)
		else $error("no launch on rising bit clock");
	a_launch_fall_pol1: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		bit_pol && $fell(bclk_lvl) |-> tx_launch_o)
		else $error("no launch on falling bit clock");
	a_rx_shared_timing: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!indep_rx |-> rx_bit_clock_o == tx_bit_clock_pin_o && rx_frame_sync_o == tx_frame_sync_i)
		else $error("receiver not on transmit timing");
	a_rx_own_timing: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		indep_rx |-> rx_bit_clock_o == rx_bit_clock_pin_i && rx_frame_sync_o == rx_frame_sync_pin_i)
		else $error("receiver not on its own timing");
	a_bit_from_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!bit_src |-> tx_bit_clock_o == tx_bit_clock_pin_i && !tx_bit_clock_pin_oe_o)
		else $error("bit clock not from pin");
	a_master_select: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		bdiv_if.src == ((mst_src ? tx_master_clock_pin_o : tx_master_clock_pin_i) ^ mst_pol))
		else $error("bit divider input wrong");
	a_master_pass: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		bit_src && bit_div == '0 && !mst_pol |-> tx_bit_clock_pin_o == bdiv_if.src)
		else $error("master not passed to bit pin");
	a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_rd_bitctl or s_rd_mstctl |=> (rdata_o & ~(ATCG_BITCTL_MSK | ATCG_MSTCTL_MSK)) == '0)
		else $error("reserved bits read nonzero");
	a_write_readback: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		wr_i && addr_i == ATCG_MSTCTL_OFS ##1 s_rd_mstctl |=> rdata_o == ($past(wdata_i, 2) & ATCG_MSTCTL_MSK))
		else $error("master word readback wrong");
	a_reset_values: assert property (@(posedge mclk_i)
		!nrst_i |=> st_reg.bitctl == ATCG_BITCTL_RST && st_reg.mstctl == ATCG_MSTCTL_RST)
		else $error("reset values wrong");
	a_pin_direction: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$changed(mst_src) |->
			tx_master_clock_pin_oe_o == mst_src && $past(tx_master_clock_pin_oe_o) != mst_src)
		else $error("master pin direction wrong");
endmodule
`default_nettype wire

// File: include/atcg_pkg.sv
// constants of the transmit clock generator: register map, fields, widths
// assumes a byte-addressed register port with 32-bit data
package atcg_pkg;
	localparam int          ATCG_AW        = 8;
	localparam int          ATCG_DW        = 32;
	localparam int          ATCG_BDIV_W    = 5;
	localparam int          ATCG_MDIV_W    = 12;
	localparam logic [7:0]  ATCG_BITCTL_OFS = 8'hB0;
	localparam logic [7:0]  ATCG_MSTCTL_OFS = 8'hB4;
	localparam logic [7:0]  ATCG_STATUS_OFS = 8'hF0;
	// bit clock control word
	localparam int          ATCG_BPOL_POS  = 7;
	localparam int          ATCG_INDEPENDENT_RX_TIMING_ENABLE_POS = 6;
	localparam int          ATCG_BSRC_POS  = 5;
	localparam logic [31:0] ATCG_BITCTL_MSK = 32'h0000_00FF;
	localparam logic [31:0] ATCG_BITCTL_RST = 32'h0000_0060;
	// master clock control word
	localparam int          ATCG_MSRC_POS  = 15;
	localparam int          ATCG_MPOL_POS  = 14;
	localparam logic [31:0] ATCG_MSTCTL_MSK = 32'h0000_CFFF;
	localparam logic [31:0] ATCG_MSTCTL_RST = 32'h0000_8000;
	// status word bit positions
	localparam int          ATCG_ST_BCLK   = 0;
	localparam int          ATCG_ST_MCLK   = 1;
	localparam int          ATCG_ST_BOE    = 2;
	localparam int          ATCG_ST_MOE    = 3;
	localparam int          ATCG_ST_W      = 4;
endpackage

// File: include/atcg_div_if.sv
// link between the clock generator top and one programmable divider
// assumes the source level is sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
interface atcg_div_if #(
	parameter int W = 5
);
	logic         src;
	logic [W-1:0] ratio;
	logic         clk_out;
	modport div (input src, input ratio, output clk_out);
	modport ctl (output src, output ratio, input clk_out);
endinterface
`default_nettype wire

// File: rtl/atcg_div.sv
// programmable clock divider: output period is (ratio+1) source periods
// assumes the source level changes at most once per system clock
`timescale 1ns/100ps
`default_nettype none
module atcg_div
	import atcg_pkg::*;
#(
	parameter int W = 5
) (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	atcg_div_if.div   bus
);
	typedef struct packed {
		logic         prev;
		logic [W:0]   cnt;
		logic         out;
	} atcg_div_st_t;

	atcg_div_st_t st_reg;
	atcg_div_st_t st_next;
	logic         edge_seen;
	logic [W:0]   last_half;
	logic [W:0]   half_len;

	// counting both source edges gives an exact 50% duty for odd ratios too
	assign edge_seen = bus.src ^ st_reg.prev;
	assign half_len  = {1'b0, bus.ratio};
	assign last_half = {bus.ratio, 1'b1};

	// ----------------------------------------
	// divider
	// ----------------------------------------
	always_comb begin
		st_next      = st_reg;
		st_next.prev = bus.src;
		if (edge_seen) begin
			if (st_reg.cnt >= last_half) begin
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
			st_next.out = (st_next.cnt <= half_len);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.clk_out = st_reg.out;

	a_div_high_end: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		edge_seen && st_reg.cnt == half_len |=> !st_reg.out)
		else $error("divider high half too long");
	a_div_wrap_rise: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		edge_seen && st_reg.cnt == last_half |=> st_reg.out && st_reg.cnt == '0)
		else $error("divider did not wrap");
endmodule
`default_nettype wire

// File: rtl/atcg_edge.sv
// edge finder for a sampled clock level: one-cycle rise and fall pulses
// assumes the level is already synchronous to the system clock
`timescale 1ns/100ps
`default_nettype none
module atcg_edge
	import atcg_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic level_i,
	output logic      rise_o,
	output logic      fall_o
);
	typedef struct packed {
		logic prev;
	} atcg_edge_st_t;

	atcg_edge_st_t st_reg;
	atcg_edge_st_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.prev = level_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rise_o = level_i & ~st_reg.prev;
	assign fall_o = ~level_i & st_reg.prev;

	a_edge_no_both: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		rise_o |-> !fall_o ##1 !rise_o)
		else $error("edge pulses overlap");
endmodule
`default_nettype wire

// File: bench/atcg_far_end.sv
// far-end converter model: external master, bit, receive clock and sync pins
// assumes the bench resolves each two-way pin from the device output enable
`timescale 1ns/100ps
`default_nettype none
module atcg_far_end (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	output logic      mst_o,
	output logic      bit_o,
	output logic      rxb_o,
	output logic      rxfs_o
);
	// wrap at 210 so every toggle rate below stays exactly periodic
	logic [7:0] cnt_reg;
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cnt_reg <= 8'h00;
			mst_o   <= 1'b0;
			bit_o   <= 1'b0;
			rxb_o   <= 1'b0;
			rxfs_o  <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg == 8'hD1) ? 8'h00 : cnt_reg + 8'h01;
			mst_o   <= mst_o ^ (cnt_reg % 8'h03 == 8'h00);
			bit_o   <= bit_o ^ (cnt_reg % 8'h05 == 8'h00);
			rxb_o   <= rxb_o ^ (cnt_reg % 8'h07 == 8'h00);
			rxfs_o  <= rxfs_o ^ (cnt_reg % 8'h0F == 8'h00);
		end
	end
endmodule
`default_nettype wire

// File: bench/atcg_top_bench.sv
// self-checking bench of the transmit clock generator
// assumes the far-end model stands in for the external converters
`timescale 1ns/100ps
`default_nettype none
module atcg_top_bench;
	import atcg_pkg::*;
	logic              mclk_i = 1'b0;
	logic              nrst_i = 1'b0;
	logic [ATCG_AW-1:0] addr_i = 8'h00;
	logic [ATCG_DW-1:0] wdata_i = 32'h0;
	logic              wr_i = 1'b0;
	logic              rd_i = 1'b0;
	logic              aux_i = 1'b0;
	logic              fs_i = 1'b1;
	logic [ATCG_DW-1:0] rdata_o;
	logic              mo, moe, bo, boe, mst, bit_c, rxb, rxfs, tbc, lau, rbc, rfs;
	logic [2:0]        mon;
	int                fail_count = 0;
	int                checked = 0;
	atcg_far_end i_atcg_far_end (.mclk_i(mclk_i), .nrst_i(nrst_i), .mst_o(mst), .bit_o(bit_c),
		.rxb_o(rxb), .rxfs_o(rxfs));
	atcg_top i_atcg_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .auxiliary_source_clock_i(aux_i),
		.tx_master_clock_pin_i(moe ? mo : mst), .tx_master_clock_pin_o(mo),
		.tx_master_clock_pin_oe_o(moe), .tx_bit_clock_pin_i(boe ? bo : bit_c),
		.tx_bit_clock_pin_o(bo), .tx_bit_clock_pin_oe_o(boe), .tx_frame_sync_i(fs_i),
		.rx_bit_clock_pin_i(rxb), .rx_frame_sync_pin_i(rxfs), .tx_bit_clock_o(tbc),
		.tx_launch_o(lau), .rx_bit_clock_o(rbc), .rx_frame_sync_o(rfs));
	assign mon = {rbc, mo, tbc};
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// auxiliary source: period of 4 system cycles
	always @(posedge mclk_i) begin
		if (nrst_i)
			aux_i <= ~aux_i ^ aux_i ^ (($time / 20) % 2 == 1);
	end
	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		// let the written word settle before a caller looks at the pins
		#1;
	endtask
	// write followed by a read of the same word with no gap in between
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", exp, rdata_o);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", exp, rdata_o);
	endtask
	// one full period of the selected clock; launch pulses tested on the bit clock
	task automatic period(input int sel, input logic pol, input logic [31:0] exp);
		logic [31:0] cnt;
		logic [31:0] lp;
		logic        low;
		int          n;
		cnt = 32'h0;
		lp  = 32'h0;
		low = 1'b0;
		// a ratio change can cut the first high phase short: sync on a whole low phase first
		for (n = 0; n < 20000 && mon[sel] !== 1'b1; n++) @(posedge mclk_i) #1;
		for (n = 0; n < 20000 && mon[sel] !== 1'b0; n++) @(posedge mclk_i) #1;
		for (n = 0; n < 20000 && mon[sel] !== 1'b1; n++) @(posedge mclk_i) #1;
		for (n = 0; n < 40000 && !(low && mon[sel] === 1'b1); n++) begin
			@(posedge mclk_i) #1;
			cnt++;
			if (mon[sel] === 1'b0)
				low = 1'b1;
			if (lau === 1'b1) begin
				lp++;
				if (sel == 0) chk("launch level", {31'h0, ~pol}, {31'h0, tbc});
			end
		end
		chk("period", exp, cnt);
		if (sel == 0) chk("launches", 32'h1, lp);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_reset_regs();
		rd(ATCG_BITCTL_OFS, ATCG_BITCTL_RST);
		rd(ATCG_MSTCTL_OFS, ATCG_MSTCTL_RST);
		chk("pin enables", 32'h3, {30'h0, moe, boe});
		$display("test reset_regs done");
	endtask
	task automatic t_reserved();
		wr(ATCG_BITCTL_OFS, 32'hFFFF_FFFF);
		rd(ATCG_BITCTL_OFS, 32'h0000_00FF);
		wr(ATCG_MSTCTL_OFS, 32'hFFFF_FFFF);
		rd(ATCG_MSTCTL_OFS, 32'h0000_CFFF);
		wr_rd(ATCG_MSTCTL_OFS, 32'h1234_F00A, 32'h0000_C00A);
		rd(8'hB8, 32'h0);
		$display("test reserved done");
	endtask
	task automatic t_dividers();
		// reserved fields written as zero throughout
		wr(ATCG_MSTCTL_OFS, 32'h0000_8002);
		wr(ATCG_BITCTL_OFS, 32'h0000_0060);
		period(1, 1'b0, 32'd12);
		period(0, 1'b0, 32'd12);
		wr(ATCG_MSTCTL_OFS, 32'h0000_8FFF);
		period(1, 1'b0, 32'd16384);
		wr(ATCG_MSTCTL_OFS, 32'h0000_8000);
		wr(ATCG_BITCTL_OFS, 32'h0000_0023);
		period(0, 1'b0, 32'd16);
		period(2, 1'b0, 32'd16);
		// look while the receive sync pin disagrees with the transmit sync
		for (int n = 0; n < 40 && rxfs !== 1'b0; n++) @(posedge mclk_i) #1;
		chk("rx sync", {31'h0, fs_i}, {31'h0, rfs});
		wr(ATCG_BITCTL_OFS, 32'h0000_00FF);
		period(0, 1'b1, 32'd128);
		period(2, 1'b1, 32'd14);
		for (int n = 0; n < 40 && rxfs !== 1'b0; n++) @(posedge mclk_i) #1;
		chk("rx own sync", 32'h0, {31'h0, rfs});
		$display("test dividers done");
	endtask
	task automatic t_sources();
		wr(ATCG_MSTCTL_OFS, 32'h0000_4000);
		wr(ATCG_BITCTL_OFS, 32'h0000_0020);
		chk("master enable", 32'h0, {31'h0, moe});
		period(0, 1'b0, 32'd6);
		wr(ATCG_BITCTL_OFS, 32'h0000_0000);
		chk("bit enable", 32'h0, {31'h0, boe});
		period(0, 1'b0, 32'd10);
		$display("test sources done");
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		t_reset_regs();
		t_reserved();
		t_dividers();
		t_sources();
		give_verdict();
	end
	initial begin
		#900us;
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
